//--- rtl/rca_baseband_end.sv
`timescale 1ns/10ps
`default_nettype none

module rca_baseband_end
    import rca_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    rca_coex_if.baseband coex,
    input  wire logic   coexEnable,
    input  wire logic   algLoad,
    input  wire logic [2:0] algSel,
    input  wire logic   prioLoad,
    input  wire logic [1:0] prioLevel,
    input  wire logic   hostWlanMaster,
    input  wire logic   airNeed,
    input  wire logic [1:0] airPrio,
    output logic        airAllowed,
    output logic        linesOwned,
    output logic [2:0]  activeAlg
);

    // ------------------------------------------------------------
    // Host configuration
    // ------------------------------------------------------------
    rca_alg_t   alg_ff;
    logic [1:0] prioThr_ff;
    logic       algValid;

    // Only the five defined codes count as a selection
    always_comb begin
        unique case (algSel)
            RCA_ALG_PKT,
            RCA_ALG_WMST,
            RCA_ALG_BMST,
            RCA_ALG_TWO,
            RCA_ALG_ALT: begin
                algValid = 1'b1;
            end
            default: begin
                algValid = 1'b0;
            end
        endcase
    end

    // Illegal codes are ignored so the lines never enter an undefined use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alg_ff <= RCA_ALG_RESET;
        end else if (algLoad && algValid) begin
            alg_ff <= rca_alg_t'(algSel);
        end
    end

    // Threshold at or above which our request is flagged high priority
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prioThr_ff <= RCA_PRIO_RESET;
        end else if (prioLoad) begin
            prioThr_ff <= prioLevel;
        end
    end

    // ------------------------------------------------------------
    // Line one synchroniser
    // ------------------------------------------------------------
    logic lineOneMeta_ff;
    logic lineOneSync_ff;
    logic lineOnePrev_ff;

    // Two stages because the WLAN chip is on its own clock
    // The third stage only feeds the slot edge detector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lineOneMeta_ff <= 1'b0;
            lineOneSync_ff <= 1'b0;
            lineOnePrev_ff <= 1'b0;
        end else begin
            lineOneMeta_ff <= coex.coexLineOne;
            lineOneSync_ff <= lineOneMeta_ff;
            lineOnePrev_ff <= lineOneSync_ff;
        end
    end

    // ------------------------------------------------------------
    // Alternating access slot tracking
    // ------------------------------------------------------------
    logic slotOurs_ff;

    // Rising medium free opens our slot, falling closes it
    // Edge tracking adds one cycle to slot open and close
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slotOurs_ff <= 1'b0;
        end else if (lineOneSync_ff && !lineOnePrev_ff) begin
            slotOurs_ff <= 1'b1;
        end else if (!lineOneSync_ff && lineOnePrev_ff) begin
            slotOurs_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Line drive and air permission
    // ------------------------------------------------------------
    logic nxt_allowed;
    logic nxt_lineTwo;
    logic nxt_lineThree;
    logic nxt_lineFour;
    logic highPrio;

    // Equal to the threshold already counts as high priority
    assign highPrio = (airPrio >= prioThr_ff);

    // Unused lines are held low in every mode
    always_comb begin
        nxt_allowed   = 1'b0;
        nxt_lineTwo   = 1'b0;
        nxt_lineThree = 1'b0;
        nxt_lineFour  = 1'b0;
        if (coexEnable) begin
            unique case (alg_ff)
                RCA_ALG_PKT: begin
                    nxt_lineTwo   = airNeed;
                    nxt_lineThree = airNeed && highPrio;
                    nxt_lineFour  = 1'b0;
                    nxt_allowed   = airNeed && lineOneSync_ff;
                end
                RCA_ALG_WMST: begin
                    nxt_allowed = airNeed && !lineOneSync_ff;
                end
                RCA_ALG_BMST: begin
                    nxt_lineTwo = airNeed;
                    nxt_allowed = airNeed;
                end
                RCA_ALG_TWO: begin
                    // The host decides per case which side is master
                    if (hostWlanMaster) begin
                        nxt_allowed = airNeed && !lineOneSync_ff;
                    end else begin
                        nxt_lineTwo = airNeed;
                        nxt_allowed = airNeed;
                    end
                end
                RCA_ALG_ALT: begin
                    nxt_allowed = airNeed && slotOurs_ff;
                end
                default: begin
                    nxt_allowed = 1'b0;
                end
            endcase
        end else begin
            // Coexistence off means no arbitration: the radio is free
            nxt_allowed = airNeed;
        end
    end

    // Registered line drive so the pins never glitch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coex.coexLineTwo   <= 1'b0;
            coex.coexLineThree <= 1'b0;
            coex.coexLineFour  <= 1'b0;
        end else begin
            coex.coexLineTwo   <= nxt_lineTwo;
            coex.coexLineThree <= nxt_lineThree;
            coex.coexLineFour  <= nxt_lineFour;
        end
    end

    // Permission to the local radio, one cycle behind the decision
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            airAllowed <= 1'b0;
        end else begin
            airAllowed <= nxt_allowed;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // A refused algorithm code leaves the read-back unchanged
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            linesOwned <= 1'b0;
            activeAlg  <= RCA_ALG_RESET;
        end else begin
            linesOwned <= coexEnable;
            activeAlg  <= alg_ff;
        end
    end

endmodule // rca_baseband_end

`default_nettype wire

//--- rtl/rca_pkg.sv
package rca_pkg;

    // ------------------------------------------------------------
    // Algorithm selection codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RCA_ALG_PKT   = 3'h1,
        RCA_ALG_WMST  = 3'h2,
        RCA_ALG_BMST  = 3'h3,
        RCA_ALG_TWO   = 3'h4,
        RCA_ALG_ALT   = 3'h5
    } rca_alg_t;

    localparam rca_alg_t RCA_ALG_RESET = RCA_ALG_PKT;
    localparam int unsigned RCA_LINE_COUNT = 4;

    // Line positions inside the four-wire bundle
    localparam int unsigned RCA_LINE_ONE   = 0;
    localparam int unsigned RCA_LINE_TWO   = 1;
    localparam int unsigned RCA_LINE_THREE = 2;
    localparam int unsigned RCA_LINE_FOUR  = 3;

    // Priority levels for the packet traffic arbitration status line
    localparam logic [1:0] RCA_PRIO_RESET = 2'h2;

endpackage : rca_pkg

//--- rtl/rca_coex_if.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Four coexistence lines between baseband and WLAN
// ------------------------------------------------------------
interface rca_coex_if;
    logic coexLineOne;   // Grant / WLAN block / medium free (WLAN drives)
    logic coexLineTwo;   // Request / baseband block (baseband drives)
    logic coexLineThree; // Status (baseband drives)
    logic coexLineFour;  // Spare line (baseband drives)

    modport baseband (
        input  coexLineOne,
        output coexLineTwo,
        output coexLineThree,
        output coexLineFour
    );
    modport wlan (
        output coexLineOne,
        input  coexLineTwo,
        input  coexLineThree,
        input  coexLineFour
    );
endinterface : rca_coex_if

`default_nettype wire

//--- rtl/rca_wlan_end.sv
`timescale 1ns/10ps
`default_nettype none

module rca_wlan_end
    import rca_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    rca_coex_if.wlan    coex,
    input  wire logic [2:0] algSel,
    input  wire logic   hostWlanMaster,
    input  wire logic   wlanNeed,
    input  wire logic   wlanSlotFree,
    output logic        wlanAllowed,
    output logic        peerRequest,
    output logic        peerHighPrio
);

    // ------------------------------------------------------------
    // Input synchronisers for the baseband lines
    // ------------------------------------------------------------
    logic [2:0] inMeta_ff;
    logic [2:0] inSync_ff;

    // Two stages because the baseband lines come from another clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            inMeta_ff <= 3'h0;
            inSync_ff <= 3'h0;
        end else begin
            inMeta_ff <= {coex.coexLineFour, coex.coexLineThree, coex.coexLineTwo};
            inSync_ff <= inMeta_ff;
        end
    end

    // ------------------------------------------------------------
    // Arbitration at the WLAN end
    // ------------------------------------------------------------
    logic nxt_lineOne;
    logic nxt_allowed;

    // In packet arbitration high-priority requests beat our own traffic; otherwise WLAN wins
    always_comb begin
        nxt_lineOne = 1'b0;
        nxt_allowed = wlanNeed;
        unique case (algSel)
            RCA_ALG_PKT: begin
                nxt_lineOne = inSync_ff[0] && (inSync_ff[1] || !wlanNeed);
                nxt_allowed = wlanNeed && !nxt_lineOne;
            end
            RCA_ALG_WMST: begin
                nxt_lineOne = wlanNeed;
            end
            RCA_ALG_BMST: begin
                nxt_allowed = wlanNeed && !inSync_ff[0];
            end
            RCA_ALG_TWO: begin
                if (hostWlanMaster) begin
                    nxt_lineOne = wlanNeed;
                end else begin
                    nxt_allowed = wlanNeed && !inSync_ff[0];
                end
            end
            RCA_ALG_ALT: begin
                nxt_lineOne = wlanSlotFree;
                nxt_allowed = wlanNeed && !wlanSlotFree;
            end
            default: begin
                nxt_allowed = wlanNeed;
            end
        endcase
    end

    // Registered line and status outputs so nothing glitches
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coex.coexLineOne <= 1'b0;
            wlanAllowed      <= 1'b0;
            peerRequest      <= 1'b0;
            peerHighPrio     <= 1'b0;
        end else begin
            coex.coexLineOne <= nxt_lineOne;
            wlanAllowed      <= nxt_allowed;
            peerRequest      <= inSync_ff[0];
            peerHighPrio     <= inSync_ff[1];
        end
    end

endmodule // rca_wlan_end

`default_nettype wire

//--- sim/rca_coex_chk.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Coexistence line checker
// ------------------------------------------------------------
module rca_coex_chk
    import rca_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       coexLineOne,
    input wire logic       coexLineTwo,
    input wire logic       coexLineThree,
    input wire logic       coexLineFour,
    input wire logic       coexEnable,
    input wire logic       airNeed,
    input wire logic [2:0] algSel,
    input wire logic       airAllowed,
    input wire logic       wlanAllowed
);
    // Windows of three to five edges cover load pulse, sync flops, slot edge and output
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence bbHoldS;
        (algSel == RCA_ALG_BMST && coexLineTwo)[*4];
    endsequence

    spare_idle_a: assert property (!coexLineFour)
        else $error("spare line driven");
    req_follow_a: assert property ((coexEnable && airNeed &&
        algSel inside {RCA_ALG_PKT, RCA_ALG_BMST})[*3] |-> coexLineTwo)
        else $error("request line missing");
    req_drop_a: assert property ((!airNeed)[*3] |-> !coexLineTwo)
        else $error("request line without need");
    off_idle_a: assert property ((!coexEnable)[*3] |-> !coexLineTwo && !coexLineThree)
        else $error("lines driven while disabled");
    status_alg_a: assert property ((algSel != RCA_ALG_PKT)[*3] |-> !coexLineThree)
        else $error("status outside arbitration");
    bb_block_a: assert property (bbHoldS |-> !wlanAllowed)
        else $error("wlan allowed while blocked");
    wlan_block_a: assert property ((coexEnable && algSel == RCA_ALG_WMST
        && coexLineOne)[*4] |-> !airAllowed)
        else $error("air allowed while blocked");
    alt_slot_a: assert property ((coexEnable && algSel == RCA_ALG_ALT
        && !coexLineOne)[*5] |-> !airAllowed)
        else $error("air allowed outside slot");
endmodule // rca_coex_chk

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import rca_pkg::*;
;
    logic       clk;
    logic       sys_rst;
    logic       coexEnable, algLoad, prioLoad, hostWlanMaster;
    logic       airNeed, wlanNeed, wlanSlotFree;
    logic [2:0] algSel;
    logic [1:0] prioLevel, airPrio;
    logic       airAllowed, linesOwned, wlanAllowed, peerRequest, peerHighPrio;
    logic [2:0] activeAlg;
    int         n_errors = 0;
    int         n_tests = 0;
    int         cyc = 0;

    rca_coex_if coex();
    rca_baseband_end rca_baseband_end_inst (.clk(clk), .sys_rst(sys_rst), .coex(coex),
        .coexEnable(coexEnable), .algLoad(algLoad), .algSel(algSel), .prioLoad(prioLoad),
        .prioLevel(prioLevel), .hostWlanMaster(hostWlanMaster), .airNeed(airNeed),
        .airPrio(airPrio), .airAllowed(airAllowed), .linesOwned(linesOwned),
        .activeAlg(activeAlg));
    rca_wlan_end rca_wlan_end_inst (.clk(clk), .sys_rst(sys_rst), .coex(coex),
        .algSel(algSel), .hostWlanMaster(hostWlanMaster), .wlanNeed(wlanNeed),
        .wlanSlotFree(wlanSlotFree), .wlanAllowed(wlanAllowed),
        .peerRequest(peerRequest), .peerHighPrio(peerHighPrio));
    rca_coex_chk rca_coex_chk_inst (.clk(clk), .sys_rst(sys_rst),
        .coexLineOne(coex.coexLineOne), .coexLineTwo(coex.coexLineTwo),
        .coexLineThree(coex.coexLineThree), .coexLineFour(coex.coexLineFour),
        .coexEnable(coexEnable), .airNeed(airNeed), .algSel(algSel),
        .airAllowed(airAllowed), .wlanAllowed(wlanAllowed));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // About 125 cycles are expected; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Inputs change 1 ns after the edge so no race with the design
    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic setAlg(input logic [2:0] c);
        algSel = c;
        algLoad = 1'b1;
        waitClk(1);
        algLoad = 1'b0;
        waitClk(1);
    endtask

    // Eight cycles exceed the longest sync and answer path
    task automatic drive(input logic an, wn, sf, hm, input logic [1:0] ap);
        airNeed = an;
        wlanNeed = wn;
        wlanSlotFree = sf;
        hostWlanMaster = hm;
        airPrio = ap;
        waitClk(8);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {coexEnable, algLoad, prioLoad, hostWlanMaster, airNeed, wlanNeed} = 6'h00;
        {wlanSlotFree, prioLevel, airPrio} = 5'h00;
        algSel = 3'h1;
        sys_rst = 1'b1;
        waitClk(8);
        sys_rst = 1'b0;
        chk("activeAlg", activeAlg, RCA_ALG_RESET);
        coexEnable = 1'b1;
        setAlg(RCA_ALG_PKT);
        drive(1, 0, 0, 0, 2'h3);
        chk("linesOwned", linesOwned, 3'h1);
        chk("request", peerRequest, 3'h1);
        chk("status", peerHighPrio, 3'h1);
        chk("full air", airAllowed, 3'h1);
        drive(1, 1, 0, 0, 2'h3);
        chk("prio air", airAllowed, 3'h1);
        drive(1, 1, 0, 0, 2'h0);
        chk("shared bb", airAllowed, 3'h0);
        chk("shared wlan", wlanAllowed, 3'h1);
        prioLevel = 2'h3;
        prioLoad = 1'b1;
        waitClk(1);
        prioLoad = 1'b0;
        drive(1, 0, 0, 0, 2'h2);
        chk("threshold", peerHighPrio, 3'h0);
        drive(0, 0, 0, 0, 2'h0);
        setAlg(3'h0);
        chk("illegal alg", activeAlg, RCA_ALG_PKT);
        setAlg(RCA_ALG_WMST);
        drive(1, 1, 0, 0, 2'h0);
        chk("wlan block", coex.coexLineOne, 3'h1);
        chk("air blocked", airAllowed, 3'h0);
        drive(1, 0, 0, 0, 2'h0);
        chk("air free", airAllowed, 3'h1);
        setAlg(RCA_ALG_BMST);
        drive(1, 1, 0, 0, 2'h0);
        chk("wlan silent", wlanAllowed, 3'h0);
        setAlg(RCA_ALG_TWO);
        chk("alg two", activeAlg, RCA_ALG_TWO);
        drive(1, 1, 0, 1, 2'h0);
        chk("two wlan mst", airAllowed, 3'h0);
        drive(1, 1, 0, 0, 2'h0);
        chk("two bb mst", wlanAllowed, 3'h0);
        setAlg(RCA_ALG_ALT);
        drive(1, 1, 1, 0, 2'h0);
        chk("medium free", coex.coexLineOne, 3'h1);
        chk("slot open", airAllowed, 3'h1);
        drive(1, 1, 0, 0, 2'h0);
        chk("slot closed", airAllowed, 3'h0);
        chk("alt line two", coex.coexLineTwo, 3'h0);
        coexEnable = 1'b0;
        drive(1, 1, 0, 0, 2'h0);
        chk("released", linesOwned, 3'h0);
        chk("off air", airAllowed, 3'h1);
        results();
    end
endmodule // tb_top

`default_nettype wire
